// ### hdl/bififo_pkg.sv
// Constants shared by the bidirectional FIFO port logic.
// Assumes both ports carry 18-bit words and the 512-word depth.
`default_nettype none
package bififo_pkg;
    localparam int WORD_W = 18;
    localparam int DEPTH = 512;
    localparam int ADDR_W = 9;
    localparam int PTR_W = 10;
    localparam int OFS_W = 9;
    localparam int OFS_COUNT = 4;
    localparam logic [PTR_W-1:0] DEPTH_CNT = 10'h200;
    localparam logic [OFS_W-1:0] OFS_RESET = 9'h008;
    localparam logic [2:0] MODE_FIFO = 3'h0;
    localparam logic [2:0] MODE_BYPASS = 3'h1;
    // Mode bit 2 set selects an offset register; bits 1:0 pick which.
    localparam int MODE_OFS_BIT = 2;
    localparam logic [1:0] OFS_AB_EMPTY = 2'h0;
    localparam logic [1:0] OFS_AB_FULL = 2'h1;
    localparam logic [1:0] OFS_BA_EMPTY = 2'h2;
    localparam logic [1:0] OFS_BA_FULL = 2'h3;
    localparam logic [PTR_W-1:0] PTR_ONE = 10'h001;
endpackage
`default_nettype wire

// ### hdl/bififo_port_b.sv
// Dual-clock bidirectional FIFO: Port B logic, flags and bypass paths.
// Port A controls arrive synchronous to clk; Port B pins are synchronous
// to port_b_clock. srst belongs to clk and is carried into the B domain.
`default_nettype none
// Operation
// - Port B ignores Port A chip select
// - Enabled write captures word into B-to-A FIFO
// - Enabled read loads next A-to-B word
// - Output enable low drives pins when reading
// - Sampled write direction forces pins off
// - Enable high: no capture, no pointer move
// - Read returns bypass word in bypass mode
// - Bypass writes go to opposite output register
// - Offsets 18 bits, value in bits 8:0
// - Empty and full flags at exact bounds
// - Almost-empty low while count at most n
// - Almost-full low while count at least D-m
// - Depth is 512 words per direction
// - Chip select high ends bypass next clock
// - Indicator rising clears bypass flags
// - Port B gets one last bypass read
// - A-to-B almost-empty made in Port B domain
// - A-to-B almost-full made in Port A domain
// - First word latency from pointer synchronisers
// - Offsets reset to eight
// - Indicator follows bypass mode two B edges later
// - Each bypass path holds one word
// - Modes 1XX reach offset registers
module bififo_port_b
    import bififo_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic port_a_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_enable_n,
    input wire logic [2:0] port_a_mode_select,
    input wire logic [WORD_W-1:0] port_a_data_in,
    output logic [WORD_W-1:0] port_a_data_out,
    input wire logic port_b_clock,
    input wire logic port_b_direction,
    input wire logic port_b_enable_n,
    input wire logic port_b_output_enable_n,
    input wire logic [WORD_W-1:0] port_b_data_in,
    output logic [WORD_W-1:0] port_b_data_out,
    output logic port_b_data_oe_n,
    output logic bypass_indicator_n,
    output logic ab_empty_flag_n,
    output logic ab_almost_empty_flag_n,
    output logic ab_almost_full_flag_n,
    output logic ab_full_flag_n,
    output logic ba_empty_flag_n,
    output logic ba_almost_empty_flag_n,
    output logic ba_almost_full_flag_n,
    output logic ba_full_flag_n
);
    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(
        input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        for (int i = PTR_W - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
        end
        from_gray = b;
    endfunction

    logic [WORD_W-1:0] ab_mem [DEPTH];
    logic [WORD_W-1:0] ba_mem [DEPTH];

    // Port A domain state.
    logic [PTR_W-1:0] ab_wptr_ff, ba_rptr_ff;
    logic [PTR_W-1:0] ab_rgray_meta, ab_rgray_ff;
    logic [PTR_W-1:0] ba_wgray_meta, ba_wgray_ff;
    logic [OFS_W-1:0] ofs_ff [OFS_COUNT];
    logic a_bypass_ff;
    logic ab_put_ff, ab_get_meta, ab_get_sync;
    logic [WORD_W-1:0] ab_byp_word_ff;
    logic ba_get_ff, ba_put_meta, ba_put_sync;
    logic ofs_req_ff, ofs_pend_ff, ofs_ack_meta, ofs_ack_sync;
    logic [OFS_W-1:0] snap_ab_empty_ff, snap_ba_full_ff;

    // Port B domain state.
    logic rst_b_meta, rst_b_ff;
    logic [PTR_W-1:0] ab_rptr_ff, ba_wptr_ff;
    logic [PTR_W-1:0] ab_wgray_meta, ab_wgray_ff;
    logic [PTR_W-1:0] ba_rgray_meta, ba_rgray_ff;
    logic byp_meta, byp_ff, byp_prev_ff;
    logic ab_get_ff, ab_put_meta, ab_put_sync;
    logic ba_put_ff, ba_get_meta, ba_get_sync;
    logic [WORD_W-1:0] ba_byp_word_ff;
    logic ofs_req_meta, ofs_req_sync, ofs_seen_ff;
    logic [OFS_W-1:0] b_ab_empty_ofs_ff, b_ba_full_ofs_ff;
    logic dir_sampled_ff;

    // Port A decode.
    logic a_sel, a_wr, a_rd, a_mode_fifo, a_mode_byp, a_mode_ofs;
    logic [PTR_W-1:0] ab_cnt_a, ba_cnt_a;
    logic ab_full_fifo, ba_empty_fifo, ab_byp_busy, ba_byp_ready;

    assign a_sel = !port_a_select_n;
    assign a_wr = a_sel && !port_a_direction && !port_a_enable_n;
    assign a_rd = a_sel && port_a_direction && !port_a_enable_n;
    assign a_mode_fifo = port_a_mode_select == MODE_FIFO;
    assign a_mode_byp = port_a_mode_select == MODE_BYPASS;
    assign a_mode_ofs = port_a_mode_select[MODE_OFS_BIT];
    assign ab_cnt_a = ab_wptr_ff - from_gray(ab_rgray_ff);
    assign ba_cnt_a = from_gray(ba_wgray_ff) - ba_rptr_ff;
    assign ab_full_fifo = ab_cnt_a == DEPTH_CNT;
    assign ba_empty_fifo = ba_cnt_a == '0;
    assign ab_byp_busy = ab_put_ff != ab_get_sync;
    assign ba_byp_ready = ba_put_sync != ba_get_ff;

    // Bypass mode is held from the registered select, so a chip select
    // going high drops it on the next clk edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            a_bypass_ff <= 1'b0;
        end else begin
            a_bypass_ff <= a_sel && a_mode_byp;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ab_rgray_meta <= '0;
            ab_rgray_ff <= '0;
            ba_wgray_meta <= '0;
            ba_wgray_ff <= '0;
            ab_get_meta <= 1'b0;
            ab_get_sync <= 1'b0;
            ba_put_meta <= 1'b0;
            ba_put_sync <= 1'b0;
            ofs_ack_meta <= 1'b0;
            ofs_ack_sync <= 1'b0;
        end else begin
            ab_rgray_meta <= to_gray(ab_rptr_ff);
            ab_rgray_ff <= ab_rgray_meta;
            ba_wgray_meta <= to_gray(ba_wptr_ff);
            ba_wgray_ff <= ba_wgray_meta;
            ab_get_meta <= ab_get_ff;
            ab_get_sync <= ab_get_meta;
            ba_put_meta <= ba_put_ff;
            ba_put_sync <= ba_put_meta;
            ofs_ack_meta <= ofs_seen_ff;
            ofs_ack_sync <= ofs_ack_meta;
        end
    end

    // Port A FIFO write into the A-to-B memory.
    always_ff @(posedge clk) begin
        if (srst) begin
            ab_wptr_ff <= '0;
        end else if (a_wr && a_mode_fifo && !ab_full_fifo) begin
            ab_wptr_ff <= ab_wptr_ff + PTR_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (a_wr && a_mode_fifo && !ab_full_fifo) begin
            ab_mem[ab_wptr_ff[ADDR_W-1:0]] <= port_a_data_in;
        end
    end

    // A-to-B bypass word: one-word holder, toggle handshake to Port B.
    always_ff @(posedge clk) begin
        if (srst) begin
            ab_put_ff <= 1'b0;
            ab_byp_word_ff <= '0;
        end else if (a_wr && a_mode_byp && a_bypass_ff && !ab_byp_busy) begin
            ab_put_ff <= !ab_put_ff;
            ab_byp_word_ff <= port_a_data_in;
        end
    end

    // B-to-A read side: FIFO pointer and bypass consumption.
    always_ff @(posedge clk) begin
        if (srst) begin
            ba_rptr_ff <= '0;
        end else if (a_rd && a_mode_fifo && !ba_empty_fifo) begin
            ba_rptr_ff <= ba_rptr_ff + PTR_ONE;
        end
    end

    // Leaving bypass drops any unread B-to-A word so the path is free.
    always_ff @(posedge clk) begin
        if (srst) begin
            ba_get_ff <= 1'b0;
        end else if (!a_bypass_ff) begin
            ba_get_ff <= ba_put_sync;
        end else if (a_rd && a_mode_byp && ba_byp_ready) begin
            ba_get_ff <= !ba_get_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_a_data_out <= '0;
        end else if (a_rd) begin
            if (a_mode_ofs) begin
                port_a_data_out <= WORD_W'(ofs_ff[port_a_mode_select[1:0]]);
            end else if (a_mode_byp && a_bypass_ff && ba_byp_ready) begin
                port_a_data_out <= ba_byp_word_ff;
            end else if (a_mode_fifo && !ba_empty_fifo) begin
                port_a_data_out <= ba_mem[ba_rptr_ff[ADDR_W-1:0]];
            end
        end
    end

    // Offset registers: only bits 8:0 are stored, upper bits read zero.
    for (genvar g = 0; g < OFS_COUNT; g++) begin : g_ofs
        always_ff @(posedge clk) begin
            if (srst) begin
                ofs_ff[g] <= OFS_RESET;
            end else if (a_wr && a_mode_ofs
                         && port_a_mode_select[1:0] == 2'(g)) begin
                ofs_ff[g] <= port_a_data_in[OFS_W-1:0];
            end
        end
    end

    // Offsets used in the B domain travel as a snapshot with a toggle
    // handshake; a write during a transfer is resent once it is acked.
    always_ff @(posedge clk) begin
        if (srst) begin
            ofs_pend_ff <= 1'b1;
            ofs_req_ff <= 1'b0;
            snap_ab_empty_ff <= OFS_RESET;
            snap_ba_full_ff <= OFS_RESET;
        end else if (ofs_pend_ff && ofs_req_ff == ofs_ack_sync) begin
            ofs_pend_ff <= a_wr && a_mode_ofs;
            ofs_req_ff <= !ofs_req_ff;
            snap_ab_empty_ff <= ofs_ff[OFS_AB_EMPTY];
            snap_ba_full_ff <= ofs_ff[OFS_BA_FULL];
        end else if (a_wr && a_mode_ofs) begin
            ofs_pend_ff <= 1'b1;
        end
    end

    // Port A flags. In bypass the full/empty pair shows the word holder.
    always_comb begin
        ab_full_flag_n = !ab_full_fifo;
        ba_empty_flag_n = !ba_empty_fifo;
        if (a_bypass_ff) begin
            ab_full_flag_n = !ab_byp_busy;
            ba_empty_flag_n = ba_byp_ready;
        end
    end

    assign ab_almost_full_flag_n =
        ab_cnt_a < (DEPTH_CNT - PTR_W'(ofs_ff[OFS_AB_FULL]));
    assign ba_almost_empty_flag_n =
        ba_cnt_a > PTR_W'(ofs_ff[OFS_BA_EMPTY]);

    // Port B domain. srst is carried over before it resets anything.
    always_ff @(posedge port_b_clock) begin
        rst_b_meta <= srst;
        rst_b_ff <= rst_b_meta;
    end

    logic b_wr, b_rd, b_byp;
    logic [PTR_W-1:0] ab_cnt_b, ba_cnt_b;
    logic ab_empty_fifo, ba_full_fifo, ab_byp_ready, ba_byp_busy;

    // Port B pins alone qualify its cycles; chip select is not used.
    assign b_wr = !port_b_direction && !port_b_enable_n;
    assign b_rd = port_b_direction && !port_b_enable_n;
    // One extra cycle of bypass after the indicator rises.
    assign b_byp = byp_ff || byp_prev_ff;
    assign ab_cnt_b = from_gray(ab_wgray_ff) - ab_rptr_ff;
    assign ba_cnt_b = ba_wptr_ff - from_gray(ba_rgray_ff);
    assign ab_empty_fifo = ab_cnt_b == '0;
    assign ba_full_fifo = ba_cnt_b == DEPTH_CNT;
    assign ab_byp_ready = ab_put_sync != ab_get_ff;
    assign ba_byp_busy = ba_put_ff != ba_get_sync;

    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ab_wgray_meta <= '0;
            ab_wgray_ff <= '0;
            ba_rgray_meta <= '0;
            ba_rgray_ff <= '0;
            byp_meta <= 1'b0;
            byp_ff <= 1'b0;
            byp_prev_ff <= 1'b0;
            ab_put_meta <= 1'b0;
            ab_put_sync <= 1'b0;
            ba_get_meta <= 1'b0;
            ba_get_sync <= 1'b0;
            ofs_req_meta <= 1'b0;
            ofs_req_sync <= 1'b0;
        end else begin
            ab_wgray_meta <= to_gray(ab_wptr_ff);
            ab_wgray_ff <= ab_wgray_meta;
            ba_rgray_meta <= to_gray(ba_rptr_ff);
            ba_rgray_ff <= ba_rgray_meta;
            byp_meta <= a_bypass_ff;
            byp_ff <= byp_meta;
            byp_prev_ff <= byp_ff;
            ab_put_meta <= ab_put_ff;
            ab_put_sync <= ab_put_meta;
            ba_get_meta <= ba_get_ff;
            ba_get_sync <= ba_get_meta;
            ofs_req_meta <= ofs_req_ff;
            ofs_req_sync <= ofs_req_meta;
        end
    end

    assign bypass_indicator_n = !byp_ff;

    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ofs_seen_ff <= 1'b0;
            b_ab_empty_ofs_ff <= OFS_RESET;
            b_ba_full_ofs_ff <= OFS_RESET;
        end else if (ofs_req_sync != ofs_seen_ff) begin
            ofs_seen_ff <= ofs_req_sync;
            b_ab_empty_ofs_ff <= snap_ab_empty_ff;
            b_ba_full_ofs_ff <= snap_ba_full_ff;
        end
    end

    // Port B write into the B-to-A memory; full writes are dropped.
    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ba_wptr_ff <= '0;
        end else if (b_wr && !b_byp && !ba_full_fifo) begin
            ba_wptr_ff <= ba_wptr_ff + PTR_ONE;
        end
    end

    always_ff @(posedge port_b_clock) begin
        if (b_wr && !b_byp && !ba_full_fifo) begin
            ba_mem[ba_wptr_ff[ADDR_W-1:0]] <= port_b_data_in;
        end
    end

    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ba_put_ff <= 1'b0;
            ba_byp_word_ff <= '0;
        end else if (b_wr && byp_ff && !ba_byp_busy) begin
            ba_put_ff <= !ba_put_ff;
            ba_byp_word_ff <= port_b_data_in;
        end
    end

    // A-to-B read pointer; it stays put whenever the enable is high.
    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ab_rptr_ff <= '0;
        end else if (b_rd && !b_byp && !ab_empty_fifo) begin
            ab_rptr_ff <= ab_rptr_ff + PTR_ONE;
        end
    end

    // Once the last bypass cycle is gone the held word is discarded.
    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            ab_get_ff <= 1'b0;
        end else if (!b_byp) begin
            ab_get_ff <= ab_put_sync;
        end else if (b_rd && ab_byp_ready) begin
            ab_get_ff <= !ab_get_ff;
        end
    end

    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            port_b_data_out <= '0;
        end else if (b_rd) begin
            if (b_byp) begin
                if (ab_byp_ready) begin
                    port_b_data_out <= ab_byp_word_ff;
                end
            end else if (!ab_empty_fifo) begin
                port_b_data_out <= ab_mem[ab_rptr_ff[ADDR_W-1:0]];
            end
        end
    end

    // The direction seen at the last edge decides whether the pins may be
    // driven, so a write cycle turns the bus off even with enable low.
    always_ff @(posedge port_b_clock) begin
        if (rst_b_ff) begin
            dir_sampled_ff <= 1'b0;
        end else begin
            dir_sampled_ff <= port_b_direction;
        end
    end

    assign port_b_data_oe_n =
        port_b_output_enable_n || !dir_sampled_ff;

    always_comb begin
        ab_empty_flag_n = !ab_empty_fifo;
        ba_full_flag_n = !ba_full_fifo;
        if (byp_ff) begin
            ab_empty_flag_n = ab_byp_ready;
            ba_full_flag_n = !ba_byp_busy;
        end
    end

    assign ab_almost_empty_flag_n =
        ab_cnt_b > PTR_W'(b_ab_empty_ofs_ff);
    assign ba_almost_full_flag_n =
        ba_cnt_b < (DEPTH_CNT - PTR_W'(b_ba_full_ofs_ff));
endmodule
`default_nettype wire

// ### verif/bififo_port_b_sva.sv
// Checker for the Port B block: pin relations in both clock domains.
// Bound to bififo_port_b; sees only the ports of that module.
`default_nettype none
module bififo_port_b_sva
    import bififo_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic port_a_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_enable_n,
    input wire logic [2:0] port_a_mode_select,
    input wire logic [WORD_W-1:0] port_a_data_out,
    input wire logic port_b_clock,
    input wire logic port_b_direction,
    input wire logic port_b_enable_n,
    input wire logic port_b_output_enable_n,
    input wire logic [WORD_W-1:0] port_b_data_out,
    input wire logic port_b_data_oe_n,
    input wire logic bypass_indicator_n,
    input wire logic ab_empty_flag_n,
    input wire logic ab_almost_empty_flag_n,
    input wire logic ba_full_flag_n,
    input wire logic ba_almost_full_flag_n
);
    // The B side leaves reset some B edges after srst, so wait that out.
    logic [2:0] b_rst_ff;
    logic b_busy;
    logic a_byp;
    always_ff @(posedge port_b_clock) begin
        b_rst_ff <= {b_rst_ff[1:0], srst};
    end
    assign b_busy = srst | (|b_rst_ff);
    assign a_byp = !port_a_select_n && port_a_mode_select == MODE_BYPASS;
    sequence byp_held;
        a_byp [*8];
    endsequence
    sequence fifo_held;
        !a_byp [*8];
    endsequence
    sequence quiet_b;
        bypass_indicator_n [*4];
    endsequence
    a_oe_off_write: assert property (@(posedge port_b_clock)
        disable iff (b_busy) !$past(port_b_direction) |-> port_b_data_oe_n)
        else $error("B pins driven in write direction");
    a_oe_drive_read: assert property (@(posedge port_b_clock)
        disable iff (b_busy) !$past(b_busy) && $past(port_b_direction)
        && !port_b_output_enable_n |-> !port_b_data_oe_n)
        else $error("B pins not driven in read direction");
    a_hold_disabled: assert property (@(posedge port_b_clock)
        disable iff (b_busy) port_b_enable_n |=> $stable(port_b_data_out))
        else $error("B output changed while disabled");
    a_bypass_enter: assert property (@(posedge port_b_clock)
        disable iff (b_busy) byp_held |-> ##[0:2] !bypass_indicator_n)
        else $error("bypass indicator late to assert");
    a_bypass_leave: assert property (@(posedge port_b_clock)
        disable iff (b_busy) fifo_held |-> ##[0:2] bypass_indicator_n)
        else $error("bypass indicator late to release");
    a_empty_almost: assert property (@(posedge port_b_clock)
        disable iff (b_busy)
        quiet_b ##0 !ab_empty_flag_n |-> !ab_almost_empty_flag_n)
        else $error("empty without almost empty");
    a_full_almost: assert property (@(posedge port_b_clock)
        disable iff (b_busy)
        quiet_b ##0 !ba_full_flag_n |-> !ba_almost_full_flag_n)
        else $error("full without almost full");
    a_ofs_upper_zero: assert property (@(posedge clk)
        disable iff (srst) !port_a_select_n && !port_a_enable_n
        && port_a_direction && port_a_mode_select[MODE_OFS_BIT]
        |-> ##[1:2] port_a_data_out[WORD_W-1:OFS_W] == 9'h000)
        else $error("offset readback upper bits set");
endmodule

bind bififo_port_b bififo_port_b_sva chk (
    .clk, .srst, .port_a_select_n, .port_a_direction, .port_a_enable_n,
    .port_a_mode_select, .port_a_data_out, .port_b_clock,
    .port_b_direction, .port_b_enable_n, .port_b_output_enable_n,
    .port_b_data_out, .port_b_data_oe_n, .bypass_indicator_n,
    .ab_empty_flag_n, .ab_almost_empty_flag_n, .ba_full_flag_n,
    .ba_almost_full_flag_n
);
`default_nettype wire

// ### verif/port_b_master.sv
// Port B bus master model: issues reads and writes on the B clock.
// Assumes the bench calls its tasks one at a time.
`default_nettype none
module port_b_master
    import bififo_pkg::*;
(
    input wire logic port_b_clock,
    output logic port_b_direction = 1'b1,
    output logic port_b_enable_n = 1'b1,
    output logic port_b_output_enable_n = 1'b1,
    output logic [WORD_W-1:0] port_b_data_in,
    input wire logic [WORD_W-1:0] port_b_data_out,
    input wire logic port_b_data_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WORD_W-1:0] word = 18'h00000;
    logic writing = 1'b0;
    logic driven_ff = 1'b0;
    // A released bus shows the inverse of the last word, never a stale copy.
    assign port_b_data_in = !port_b_data_oe_n ? port_b_data_out
        : writing ? word : ~word;
    always @(posedge port_b_clock) driven_ff <= !port_b_data_oe_n;
    task automatic park(input logic dir, input logic oe);
        @(negedge port_b_clock);
        port_b_direction = dir;
        port_b_enable_n = 1'b1;
        port_b_output_enable_n = oe;
        writing = 1'b0;
    endtask
    task automatic b_write(input logic [WORD_W-1:0] w);
        if (driven_ff) park(1'b1, 1'b1);
        @(negedge port_b_clock);
        port_b_direction = 1'b0;
        port_b_enable_n = 1'b0;
        port_b_output_enable_n = 1'b1;
        word = w;
        writing = 1'b1;
    endtask
    task automatic b_read(input logic oe, output logic [WORD_W-1:0] w);
        @(negedge port_b_clock);
        port_b_direction = 1'b1;
        port_b_enable_n = 1'b0;
        port_b_output_enable_n = oe;
        writing = 1'b0;
        @(negedge port_b_clock);
        port_b_enable_n = 1'b1;
        w = port_b_data_out;
    endtask
endmodule
`default_nettype wire

// ### verif/test_bififo_port_b_flags_bypass.sv
// Bench for the Port B block: offsets, both FIFO directions, bypass.
// Assumes the Port B master model and the bound checker are compiled.
`default_nettype none
module test_bififo_port_b_flags_bypass
    import bififo_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [1:0] idx; logic [17:0] wr; logic [17:0] rd;} row_s;
    // Only the OFS_BA_EMPTY offset sets bit 8; a small part would need it kept zero.
    row_s rows[4] = '{'{OFS_AB_EMPTY, 18'h3fe03, 18'h00003},
        '{OFS_AB_FULL, 18'h20004, 18'h00004},
        '{OFS_BA_EMPTY, 18'h00105, 18'h00105},
        '{OFS_BA_FULL, 18'h3fc02, 18'h00002}};
    logic clk = 1'b0, srst = 1'b1, port_b_clock = 1'b0;
    logic port_a_select_n = 1'b1, port_a_direction = 1'b1;
    logic port_a_enable_n = 1'b1;
    logic [2:0] port_a_mode_select = 3'h0;
    logic [WORD_W-1:0] port_a_data_in = 18'h00000, w;
    logic [WORD_W-1:0] port_a_data_out, port_b_data_in, port_b_data_out;
    logic port_b_direction, port_b_enable_n, port_b_output_enable_n;
    logic port_b_data_oe_n, bypass_indicator_n;
    logic ab_empty_flag_n, ab_almost_empty_flag_n, ab_almost_full_flag_n;
    logic ab_full_flag_n, ba_empty_flag_n, ba_almost_empty_flag_n;
    logic ba_almost_full_flag_n, ba_full_flag_n;
    int n_fail = 0, n_compared = 0, cycles = 0, filled = 0;
    initial forever #10 clk = ~clk;
    initial begin
        #1.3;
        forever #3 port_b_clock = ~port_b_clock;
    end
    bififo_port_b dut (.clk, .srst, .port_a_select_n, .port_a_direction,
        .port_a_enable_n, .port_a_mode_select, .port_a_data_in,
        .port_a_data_out, .port_b_clock, .port_b_direction,
        .port_b_enable_n, .port_b_output_enable_n, .port_b_data_in,
        .port_b_data_out, .port_b_data_oe_n, .bypass_indicator_n,
        .ab_empty_flag_n, .ab_almost_empty_flag_n, .ab_almost_full_flag_n,
        .ab_full_flag_n, .ba_empty_flag_n, .ba_almost_empty_flag_n,
        .ba_almost_full_flag_n, .ba_full_flag_n);
    port_b_master bm (.port_b_clock, .port_b_direction, .port_b_enable_n,
        .port_b_output_enable_n, .port_b_data_in, .port_b_data_out,
        .port_b_data_oe_n);
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic a_hold(input logic [2:0] m, input logic sel_n);
        @(negedge clk);
        port_a_select_n = sel_n;
        port_a_mode_select = m;
    endtask
    task automatic a_op(input logic [2:0] m, input logic rd,
        input logic [17:0] x);
        a_hold(m, 1'b0);
        port_a_enable_n = 1'b0;
        port_a_direction = rd;
        port_a_data_in = x;
        @(negedge clk);
        port_a_enable_n = 1'b1;
    endtask
    task automatic a_read(input logic [2:0] m, input logic [17:0] exp);
        a_op(m, 1'b1, 18'h00000);
        @(negedge clk);
        chk_word(port_a_data_out, exp);
    endtask
    // Back-to-back B writes; the word index doubles as its data.
    task automatic fill(input int n);
        while (filled < n) begin
            bm.b_write(18'(filled));
            filled++;
        end
        bm.park(1'b1, 1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic wait_ind(input logic v);
        for (int i = 0; i < 30 && bypass_indicator_n !== v; i++) begin
            @(negedge port_b_clock);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk_flag(ab_empty_flag_n, 1'b0);
        chk_flag(ba_empty_flag_n, 1'b0);
        chk_flag(ba_full_flag_n, 1'b1);
        chk_flag(ab_full_flag_n, 1'b1);
        chk_flag(ab_almost_full_flag_n, 1'b1);
        chk_flag(port_b_data_oe_n, 1'b1);
        for (int i = 0; i < OFS_COUNT; i++) begin
            a_read({1'b1, 2'(i)}, {9'h000, OFS_RESET});
        end
        foreach (rows[i]) begin
            a_op({1'b1, rows[i].idx}, 1'b0, rows[i].wr);
            a_read({1'b1, rows[i].idx}, rows[i].rd);
        end
        $display("test reset and offsets done");
        repeat (20) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            a_op(MODE_FIFO, 1'b0, 18'h00100 + 18'(i));
            repeat (8) @(negedge clk);
            chk_flag(ab_almost_empty_flag_n, i == 3);
        end
        port_a_mode_select = 3'h4;
        port_a_select_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            bm.b_read(1'b0, w);
            chk_word(w, 18'h00100 + 18'(i < 4 ? i : 3));
        end
        chk_flag(ab_empty_flag_n, 1'b0);
        chk_flag(port_b_data_oe_n, 1'b0);
        bm.park(1'b0, 1'b0);
        @(negedge port_b_clock);
        chk_flag(port_b_data_oe_n, 1'b1);
        $display("test a to b done");
        fill(261);
        chk_flag(ba_almost_empty_flag_n, 1'b0);
        fill(262);
        chk_flag(ba_almost_empty_flag_n, 1'b1);
        fill(509);
        chk_flag(ba_almost_full_flag_n, 1'b1);
        fill(510);
        chk_flag(ba_almost_full_flag_n, 1'b0);
        chk_flag(ba_full_flag_n, 1'b1);
        fill(513);
        chk_flag(ba_full_flag_n, 1'b0);
        for (int i = 0; i < DEPTH; i++) begin
            a_read(MODE_FIFO, 18'(i));
        end
        repeat (8) @(negedge clk);
        chk_flag(ba_empty_flag_n, 1'b0);
        $display("test b to a done");
        for (int e = 0; e < 2; e++) begin
            a_hold(MODE_BYPASS, 1'b0);
            wait_ind(1'b0);
            chk_flag(bypass_indicator_n, 1'b0);
            a_op(MODE_BYPASS, 1'b0, 18'h2a5a5 + 18'(e));
            repeat (4) @(negedge clk);
            chk_flag(ab_full_flag_n, 1'b0);
            if (e == 0) begin
                bm.b_read(1'b1, w);
                chk_word(w, 18'h2a5a5);
                bm.b_write(18'h15a5a);
                bm.park(1'b1, 1'b1);
                repeat (4) @(negedge clk);
                a_read(MODE_BYPASS, 18'h15a5a);
            end
            a_hold(e == 1 ? MODE_BYPASS : MODE_FIFO, e == 1);
            wait_ind(1'b1);
            chk_flag(bypass_indicator_n, 1'b1);
            repeat (4) @(negedge clk);
            chk_flag(ab_empty_flag_n, 1'b0);
        end
        a_op(MODE_FIFO, 1'b0, 18'h00777);
        repeat (8) @(negedge clk);
        bm.b_read(1'b1, w);
        chk_word(w, 18'h00777);
        $display("test bypass done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
